// file: inc/dual_timer_params.svh
// Register indices, field positions, reset values and prescaler taps for the dual timer
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH
// Register indices; the byte address is four times the index
`define IDX_PERIOD_A 8'h14
`define IDX_PULSE_A 8'h18
`define IDX_CTRL_A 8'h27
`define IDX_CTRL_B 8'h28
`define IDX_PERIOD_B 8'h16
`define IDX_PULSE_B 8'h1A
`define IDX_COUNT 8'h30
`define IDX_CONFIG 8'h31
// Reset values
`define RST_COMPARE 8'hFF
`define RST_CTRL 8'h00
// Control register fields
`define CTRL_PRESET_BIT 7
`define CTRL_CLK_HI 6
`define CTRL_CLK_LO 4
`define CTRL_RUN_BIT 3
`define CTRL_MODE_HI 2
`define CTRL_MODE_LO 0
// Config register fields
`define CFG_PRESCALER_BIT 0
`define CFG_SLOW_BIT 1
// Prescaler taps: high_freq_clock divided by 2^n
`define PRE_WIDTH 11
`define TAP_DIV11 11
`define TAP_DIV7 7
`define TAP_DIV5 5
`define TAP_DIV3 3
`define LOWF_DIV_WIDTH 3
// Response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: inc/dual_timer_pkg.sv
// Types shared by the dual timer design files
package dual_timer_pkg;
    // Clock source codes
    typedef enum logic [2:0] {
        CLK_DIV11_OR_LOWF8 = 3'h0,
        CLK_DIV7 = 3'h1,
        CLK_DIV5 = 3'h2,
        CLK_DIV3 = 3'h3,
        CLK_LOWF = 3'h4,
        CLK_DIV1 = 3'h5,
        CLK_UNDIV = 3'h6,
        CLK_PIN = 3'h7
    } clk_sel_t;
    // Unit A modes
    typedef enum logic [2:0] {
        MODE_A_TIMER = 3'h0,
        MODE_A_DIVIDER = 3'h1,
        MODE_A_PWM = 3'h2,
        MODE_A_CASCADE = 3'h3
    } mode_a_t;
    // Unit B modes
    typedef enum logic [2:0] {
        MODE_B_TIMER = 3'h0,
        MODE_B_DIVIDER = 3'h1,
        MODE_B_PWM = 3'h2,
        MODE_B_RESERVED = 3'h3,
        MODE_B_TIMER16 = 3'h4,
        MODE_B_WARMUP = 3'h5,
        MODE_B_PWM16 = 3'h6,
        MODE_B_PULSE16 = 3'h7
    } mode_b_t;
    // Width of one counter unit
    typedef logic [7:0] count_t;
endpackage : dual_timer_pkg

// file: design/timer_unit.sv
// One 8-bit up counter with period compare and a toggling output flip-flop
`timescale 1ns/1ns
module timer_unit #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic run_in,
    input wire logic tick_in,
    input wire logic cmp_en_in,
    input wire logic clr_in,
    input wire logic preset_in,
    input wire logic [WIDTH-1:0] period_in,
    output logic [WIDTH-1:0] count_out,
    output logic ovf_out,
    output logic match_out,
    output logic ff_out
);
    logic [WIDTH-1:0] count_r; // Running count
    logic ff_r; // Output flip-flop

    // Wrap pulse feeds a cascaded upper unit
    assign ovf_out = run_in && tick_in && (&count_r);
    // Compare hit, only when the unit compares on its own
    assign match_out = run_in && tick_in && cmp_en_in && (count_r == period_in);
    assign count_out = count_r;
    assign ff_out = ff_r;

    // Counter: stopped clears it, a hit returns it to zero
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_r <= '0;
        end else if (ce_in) begin
            if (!run_in) begin
                count_r <= '0;
            end else if (clr_in || match_out) begin
                count_r <= '0;
            end else if (tick_in) begin
                count_r <= count_r + 1'b1;
            end
        end
    end

    // Flip-flop follows the preset while stopped and toggles on each hit
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ff_r <= 1'b0;
        end else if (ce_in) begin
            if (!run_in) begin
                ff_r <= preset_in;
            end else if (clr_in || match_out) begin
                ff_r <= ~ff_r;
            end
        end
    end
endmodule : timer_unit

// file: design/dual_timer.sv
// Dual 8-bit timer with cascade into 16 bits, behind an AXI4-Lite register slave
//
// Contract
// - Period and pulse A registers, reset all ones
// - Control A resets to zero, stopped
// - Clock select picks prescaled, low, or pin
// - Run low stops and clears; high counts
// - Mode A field: timer, divider, PWM, cascade
// - Cascade needs mode A 011; B picks mode
// - Cascade: clock from A, run from B
// - Unit B has control, period, pulse registers
// - Mode B field covers eight modes
// - Mode B top bit clocks B from A wrap
`timescale 1ns/1ns
`include "dual_timer_params.svh"
module dual_timer (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic low_freq_clock_in,
    input wire logic pin_a_in,
    input wire logic pin_b_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic flipflop_a_out,
    output logic flipflop_b_out
);
    import dual_timer_pkg::*;

    logic [7:0] period_compare_a_r; // Period compare A
    logic [7:0] pulse_compare_a_r; // Pulse compare A, kept for PWM modes
    logic [7:0] period_compare_b_r; // Period compare B
    logic [7:0] pulse_compare_b_r; // Pulse compare B
    logic [7:0] timer_a_control_r; // Control A
    logic [7:0] timer_b_control_r; // Control B
    logic [1:0] config_r; // Prescaler select and slow-mode bits
    logic [`PRE_WIDTH-1:0] pre_r; // Free-running divider of the system clock
    logic [`LOWF_DIV_WIDTH-1:0] lowf_div_r; // Divider of low-frequency edges
    logic [2:0] lowf_sync_r; // Two sync stages plus edge history
    logic [2:0] pin_a_sync_r; // Pin A sync and history
    logic [2:0] pin_b_sync_r; // Pin B sync and history
    logic lowf_edge, lowf_div_tick, pin_a_edge, pin_b_edge;
    logic cascade, run_a, run_b, tick_a, tick_b, ovf_a, match16, clr16;
    count_t count_a, count_b;
    logic [7:0] aw_addr_r; // Captured write address
    logic aw_held_r; // Write address taken, waiting for data
    logic [7:0] w_data_r; // Captured write data, low byte
    logic w_strb_r; // Low-lane strobe of captured data
    logic w_held_r; // Write data taken, waiting for address
    logic do_write;
    logic [7:0] wr_idx, rd_idx;
    logic [31:0] rd_word;
    logic rd_hit;

    // Synchronisers: only the third stage history is compared with the second
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lowf_sync_r <= 3'h0;
            pin_a_sync_r <= 3'h0;
            pin_b_sync_r <= 3'h0;
        end else if (ce_in) begin
            lowf_sync_r <= {lowf_sync_r[1:0], low_freq_clock_in};
            pin_a_sync_r <= {pin_a_sync_r[1:0], pin_a_in};
            pin_b_sync_r <= {pin_b_sync_r[1:0], pin_b_in};
        end
    end
    // Rising edges, seen only after both sync flops
    assign lowf_edge = lowf_sync_r[1] && !lowf_sync_r[2];
    assign pin_a_edge = pin_a_sync_r[1] && !pin_a_sync_r[2];
    assign pin_b_edge = pin_b_sync_r[1] && !pin_b_sync_r[2];

    // Prescalers; the system clock stands in for the high-frequency clock
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_r <= '0;
            lowf_div_r <= '0;
        end else if (ce_in) begin
            pre_r <= pre_r + 1'b1;
            if (lowf_edge) begin
                lowf_div_r <= lowf_div_r + 1'b1;
            end
        end
    end
    assign lowf_div_tick = lowf_edge && (&lowf_div_r);

    // Source tick for a clock select code
    function automatic logic src_tick(input logic [2:0] sel, input logic pin_edge);
        logic slow_or_psel;
        slow_or_psel = config_r[`CFG_PRESCALER_BIT] || config_r[`CFG_SLOW_BIT];
        unique case (clk_sel_t'(sel))
            CLK_DIV11_OR_LOWF8: src_tick = slow_or_psel ? lowf_div_tick
                                                        : &pre_r[`TAP_DIV11-1:0];
            CLK_DIV7: src_tick = &pre_r[`TAP_DIV7-1:0];
            CLK_DIV5: src_tick = &pre_r[`TAP_DIV5-1:0];
            CLK_DIV3: src_tick = &pre_r[`TAP_DIV3-1:0];
            CLK_LOWF: src_tick = lowf_edge;
            CLK_DIV1: src_tick = pre_r[0];
            CLK_UNDIV: src_tick = 1'b1;
            CLK_PIN: src_tick = pin_edge;
        endcase
    endfunction : src_tick

    // Cascade steering: A takes its run from B but keeps its own source
    assign cascade = (timer_a_control_r[`CTRL_MODE_HI:`CTRL_MODE_LO] == MODE_A_CASCADE);
    assign run_b = timer_b_control_r[`CTRL_RUN_BIT];
    assign run_a = cascade ? run_b : timer_a_control_r[`CTRL_RUN_BIT];
    assign tick_a = src_tick(timer_a_control_r[`CTRL_CLK_HI:`CTRL_CLK_LO], pin_a_edge);
    // Upper-mode B counts A wraps and ignores its own select
    assign tick_b = timer_b_control_r[`CTRL_MODE_HI] ? ovf_a
                  : src_tick(timer_b_control_r[`CTRL_CLK_HI:`CTRL_CLK_LO], pin_b_edge);
    // 16-bit compare on the combined count, at an A source tick
    assign match16 = cascade && timer_b_control_r[`CTRL_MODE_HI] && run_b && tick_a
                  && ({count_b, count_a} == {period_compare_b_r, period_compare_a_r});
    assign clr16 = match16;

    // Lower unit; wraps freely while cascaded so B sees its overflow
    timer_unit #(.WIDTH(8)) unit_a (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .run_in(run_a),
        .tick_in(tick_a),
        .cmp_en_in(!cascade),
        .clr_in(clr16),
        .preset_in(timer_a_control_r[`CTRL_PRESET_BIT]),
        .period_in(period_compare_a_r),
        .count_out(count_a),
        .ovf_out(ovf_a),
        .match_out(),
        .ff_out(flipflop_a_out)
    );

    // Upper unit; B preset drives the output in 16-bit operation
    timer_unit #(.WIDTH(8)) unit_b (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .run_in(run_b),
        .tick_in(tick_b),
        .cmp_en_in(!timer_b_control_r[`CTRL_MODE_HI]),
        .clr_in(clr16),
        .preset_in(timer_b_control_r[`CTRL_PRESET_BIT]),
        .period_in(period_compare_b_r),
        .count_out(count_b),
        .ovf_out(),
        .match_out(),
        .ff_out(flipflop_b_out)
    );

    // Write channel: address and data are taken in either order
    // Readies drop while frozen, so a master never sees a handshake that is not stored
    assign s_axi_awready = ce_in && !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = ce_in && !w_held_r && !s_axi_bvalid;
    assign do_write = aw_held_r && w_held_r;
    assign wr_idx = {2'h0, aw_addr_r[7:2]};

    // Capture of write address and data, released by the response
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_addr_r <= 8'h00;
            aw_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (ce_in) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_held_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata[7:0];
                w_strb_r <= s_axi_wstrb[0];
                w_held_r <= 1'b1;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped and read-only words answer with an error
                case (wr_idx)
                    `IDX_PERIOD_A, `IDX_PULSE_A, `IDX_CTRL_A, `IDX_CTRL_B,
                    `IDX_PERIOD_B, `IDX_PULSE_B, `IDX_CONFIG: s_axi_bresp <= `RESP_OKAY;
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register store; no write is blocked while running, that discipline is software's
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            period_compare_a_r <= `RST_COMPARE;
            pulse_compare_a_r <= `RST_COMPARE;
            period_compare_b_r <= `RST_COMPARE;
            pulse_compare_b_r <= `RST_COMPARE;
            timer_a_control_r <= `RST_CTRL;
            timer_b_control_r <= `RST_CTRL;
            config_r <= 2'h0;
        end else if (ce_in && do_write && w_strb_r) begin
            case (wr_idx)
                `IDX_PERIOD_A: period_compare_a_r <= w_data_r;
                `IDX_PULSE_A: pulse_compare_a_r <= w_data_r;
                `IDX_CTRL_A: timer_a_control_r <= w_data_r;
                `IDX_CTRL_B: timer_b_control_r <= w_data_r;
                `IDX_PERIOD_B: period_compare_b_r <= w_data_r;
                `IDX_PULSE_B: pulse_compare_b_r <= w_data_r;
                `IDX_CONFIG: config_r <= w_data_r[1:0];
                default: ;
            endcase
        end
    end

    // Read decode; counts show the live state of both units
    assign rd_idx = {2'h0, s_axi_araddr[7:2]};
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (rd_idx)
            `IDX_PERIOD_A: rd_word[7:0] = period_compare_a_r;
            `IDX_PULSE_A: rd_word[7:0] = pulse_compare_a_r;
            `IDX_CTRL_A: rd_word[7:0] = timer_a_control_r;
            `IDX_CTRL_B: rd_word[7:0] = timer_b_control_r;
            `IDX_PERIOD_B: rd_word[7:0] = period_compare_b_r;
            `IDX_PULSE_B: rd_word[7:0] = pulse_compare_b_r;
            `IDX_COUNT: rd_word[15:0] = {count_b, count_a};
            `IDX_CONFIG: rd_word[1:0] = config_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: one cycle from address to data
    assign s_axi_arready = ce_in && !s_axi_rvalid;
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ce_in) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : dual_timer

// file: sim/dual_timer_monitor.sv
// Register bus checker for the dual timer, bound to its top module
`timescale 1ns/1ns
module dual_timer_monitor (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // One clock domain, so one clocking and one reset serve every check
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    // Both halves taken together: response two edges later, not sooner
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && ce_in |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after request");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce_in |=> s_axi_rvalid)
        else $error("read data not one cycle after request");
    // An answer stands unchanged until the master takes it
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");
    resp_clear_a: assert property (s_axi_bvalid && s_axi_bready && ce_in |=> !s_axi_bvalid)
        else $error("write response not cleared");
    // No new request is taken while an answer is pending
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    // Registers are one byte, the count word two: upper half always zero
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    slverr_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0) else $error("refused read returned data");
endmodule : dual_timer_monitor
bind dual_timer dual_timer_monitor u_mon (.clk_sys_in, .nrst_in, .ce_in, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: sim/dual_timer_bench.sv
// Self-checking bench for the dual timer: registers, clock sources, cascade
`timescale 1ns/1ns
`include "dual_timer_params.svh"
module dual_timer_bench;
    logic clk_sys_in = 1'b0, nrst_in = 1'b0, low_freq_clock_in = 1'b0, pin_a_in = 1'b0;
    logic ce_in = 1'b1; // Clock enable, dropped once to check that state freezes
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic flipflop_a_out, flipflop_b_out;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    int seed = 32'h02CD9AA5; // Fixed seed keeps runs repeatable
    // Clock source codes and their tick spacing in system cycles
    logic [2:0] cs [6] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h4, 3'h0};
    int dv [6] = '{1, 2, 8, 32, 8, 64};
    // Unit B pin shares the unit A pin stimulus, so both units count the same pulses
    dual_timer u_dut (.clk_sys_in, .nrst_in, .ce_in, .low_freq_clock_in, .pin_a_in,
        .pin_b_in(pin_a_in), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flipflop_a_out, .flipflop_b_out);
    // System clock 100 ns; low clock period 8 cycles, driven on rising edges
    always #50 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        if (cyc[1:0] == 2'h3) low_freq_clock_in <= ~low_freq_clock_in;
    end
    // Hang guard: longest test is far below this
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Write one byte; address and data released each when taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk_sys_in);
        s_axi_awaddr <= {idx[5:0], 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr
    // Read one word and compare data and response
    task automatic rc(input string what, input logic [7:0] idx, input logic [31:0] exp,
        input logic [1:0] er);
        @(posedge clk_sys_in);
        s_axi_araddr <= {idx[5:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(what, exp, s_axi_rdata);
        chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rc
    function automatic logic ff(input logic b);
        return b ? flipflop_b_out : flipflop_a_out;
    endfunction : ff
    // Cycles between two toggles of an output flip-flop
    task automatic per(input logic b, output int n);
        logic v;
        v = ff(b);
        while (ff(b) === v) @(posedge clk_sys_in);
        v = ff(b);
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (ff(b) === v);
    endtask : per
    // Toggle spacing: ticks per wrap times cycles per tick
    function automatic int exp_per(input int div, input int pb, input int pa);
        return div * (pb * 256 + pa + 1);
    endfunction : exp_per
    initial begin
        logic [7:0] v, ix [4];
        int p, n;
        ix = '{`IDX_PERIOD_A, `IDX_PULSE_A, `IDX_PERIOD_B, `IDX_PULSE_B};
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 4; i++) rc("compare reset", ix[i], 32'hFF, `RESP_OKAY);
        rc("control a reset", `IDX_CTRL_A, 32'h0, `RESP_OKAY);
        rc("control b reset", `IDX_CTRL_B, 32'h0, `RESP_OKAY);
        $display("test reset values done");
        // Stopped units: every mode code stored, preset drives the flip-flop
        for (int m = 0; m < 8; m++) begin
            v = $random(seed);
            wr(ix[m % 4], v, `RESP_OKAY);
            rc("compare rw", ix[m % 4], {24'h0, v}, `RESP_OKAY);
            v = {v[7:4], 1'b0, m[2:0]};
            wr(`IDX_CTRL_B, v, `RESP_OKAY);
            rc("control b rw", `IDX_CTRL_B, {24'h0, v}, `RESP_OKAY);
            chk("flipflop b preset", {31'h0, v[7]}, {31'h0, flipflop_b_out});
            v[2] = 1'b0;
            wr(`IDX_CTRL_A, v, `RESP_OKAY);
            rc("control a rw", `IDX_CTRL_A, {24'h0, v}, `RESP_OKAY);
            chk("flipflop a preset", {31'h0, v[7]}, {31'h0, flipflop_a_out});
        end
        wr(`IDX_CTRL_A, 8'h00, `RESP_OKAY);
        wr(`IDX_CTRL_B, 8'h00, `RESP_OKAY);
        wr(8'h20, 8'h5A, `RESP_SLVERR);
        rc("unmapped read", 8'h20, 32'h0, `RESP_SLVERR);
        wr(`IDX_COUNT, 8'h5A, `RESP_SLVERR);
        $display("test register access done");
        // Six clock sources, all but the 2^7 and 2^11 taps and the pin: period set while stopped, start, time, stop
        for (int k = 0; k < 6; k++) begin
            p = {$random(seed)} % 8 + 1;
            if (k == 5) wr(`IDX_CONFIG, 8'h01, `RESP_OKAY);
            wr(`IDX_PERIOD_A, p[7:0], `RESP_OKAY);
            wr(`IDX_CTRL_A, {1'b0, cs[k], 1'b1, 3'h0}, `RESP_OKAY);
            per(1'b0, n);
            chk("toggle spacing a", exp_per(dv[k], 0, p), n);
            wr(`IDX_CTRL_A, {1'b0, cs[k], 1'b0, 3'h0}, `RESP_OKAY);
            rc("count after stop", `IDX_COUNT, 32'h0, `RESP_OKAY);
        end
        wr(`IDX_CONFIG, 8'h00, `RESP_OKAY);
        $display("test clock sources done");
        // Pin source on both units: count rising edges, no wrap below period
        wr(`IDX_PERIOD_A, 8'hFF, `RESP_OKAY);
        wr(`IDX_PERIOD_B, 8'hFF, `RESP_OKAY);
        wr(`IDX_CTRL_A, 8'h78, `RESP_OKAY);
        wr(`IDX_CTRL_B, 8'h78, `RESP_OKAY);
        p = {$random(seed)} % 16 + 5;
        // The last three pulses come while the clock enable is low and must be lost
        for (int i = 0; i < p + 3; i++) begin
            if (i == p) ce_in <= 1'b0;
            repeat (4) @(posedge clk_sys_in) pin_a_in <= 1'b1;
            repeat (4) @(posedge clk_sys_in) pin_a_in <= 1'b0;
        end
        ce_in <= 1'b1;
        rc("pin count", `IDX_COUNT, {16'h0, p[7:0], p[7:0]}, `RESP_OKAY);
        wr(`IDX_CTRL_A, 8'h70, `RESP_OKAY);
        wr(`IDX_CTRL_B, 8'h70, `RESP_OKAY);
        $display("test pin source done");
        // Cascade: A in mode 011 sets the clock, B starts and picks 16-bit
        p = {$random(seed)} % 256;
        wr(`IDX_PERIOD_A, p[7:0], `RESP_OKAY);
        wr(`IDX_PERIOD_B, 8'h01, `RESP_OKAY);
        wr(`IDX_CTRL_A, 8'h63, `RESP_OKAY);
        wr(`IDX_CTRL_B, 8'h0C, `RESP_OKAY);
        per(1'b1, n);
        chk("cascade spacing", exp_per(1, 1, p), n);
        wr(`IDX_CTRL_B, 8'h04, `RESP_OKAY);
        rc("cascade stop count", `IDX_COUNT, 32'h0, `RESP_OKAY);
        $display("test cascade done");
        results();
    end
endmodule : dual_timer_bench
